// ==== include/ucnt_pkg.sv ====
`default_nettype none

package ucnt_pkg;

  // ********************************************************************
  // Limits and bus geometry.
  // ********************************************************************
  localparam int unsigned UCNT_MAX_WIDTH = 64;
  localparam int unsigned UCNT_ADDR_W    = 5;
  localparam int unsigned UCNT_DATA_W    = 32;

  // ********************************************************************
  // Register byte offsets.
  // ********************************************************************
  localparam logic [UCNT_ADDR_W-1:0] UCNT_ADDR_CTRL     = 5'h00;
  localparam logic [UCNT_ADDR_W-1:0] UCNT_ADDR_STATUS   = 5'h04;
  localparam logic [UCNT_ADDR_W-1:0] UCNT_ADDR_COUNT_LO = 5'h08;
  localparam logic [UCNT_ADDR_W-1:0] UCNT_ADDR_COUNT_HI = 5'h0c;
  localparam logic [UCNT_ADDR_W-1:0] UCNT_ADDR_LOAD_LO  = 5'h10;
  localparam logic [UCNT_ADDR_W-1:0] UCNT_ADDR_LOAD_HI  = 5'h14;
  localparam logic [UCNT_ADDR_W-1:0] UCNT_ADDR_CONFIG   = 5'h18;

  // ********************************************************************
  // Field positions.
  // ********************************************************************
  localparam int unsigned UCNT_CTRL_RUN_BIT   = 0;
  localparam int unsigned UCNT_CTRL_CLEAR_BIT = 1;
  localparam int unsigned UCNT_CTRL_LOAD_BIT  = 2;
  localparam int unsigned UCNT_STAT_TERM_BIT  = 0;
  localparam int unsigned UCNT_STAT_WRAP_BIT  = 1;
  localparam int unsigned UCNT_STAT_UP_BIT    = 2;
  localparam int unsigned UCNT_CFG_WIDTH_POS  = 0;
  localparam int unsigned UCNT_CFG_BINPT_POS  = 8;
  localparam int unsigned UCNT_CFG_SIGNED_BIT = 16;
  localparam int unsigned UCNT_CFG_KIND_BIT   = 17;
  localparam int unsigned UCNT_CFG_DIR_POS    = 18;
  localparam int unsigned UCNT_CFG_LOAD_BIT   = 20;
  localparam int unsigned UCNT_CFG_CLEAR_BIT  = 21;
  localparam int unsigned UCNT_CFG_EN_BIT     = 22;

  // ********************************************************************
  // Reset values and responses.
  // ********************************************************************
  localparam logic       UCNT_CTRL_RUN_RST = 1'b1;
  localparam logic [1:0] UCNT_RESP_OKAY    = 2'b00;
  localparam logic [1:0] UCNT_RESP_SLVERR  = 2'b10;

  // ********************************************************************
  // Types.
  // ********************************************************************
  typedef enum logic [1:0] {
    UCNT_DIR_UP     = 2'b00,
    UCNT_DIR_DOWN   = 2'b01,
    UCNT_DIR_UPDOWN = 2'b10
  } ucnt_dir_t;

  typedef enum logic {
    UCNT_FREE    = 1'b0,
    UCNT_LIMITED = 1'b1
  } ucnt_kind_t;

  typedef enum logic [1:0] {
    UCNT_WR_IDLE      = 2'b00,
    UCNT_WR_HAVE_ADDR = 2'b01,
    UCNT_WR_HAVE_DATA = 2'b10,
    UCNT_WR_RESP      = 2'b11
  } ucnt_wr_state_t;

endpackage

`default_nettype wire

// ==== core/ucnt_core.sv ====
`default_nettype none

module ucnt_core #(
  parameter int unsigned      WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT  = '0,
  parameter logic [WIDTH-1:0] STEP  = '1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             aclken,
  input  wire logic             clear,
  input  wire logic             advance,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             restart,
  input  wire logic             count_up,
  output logic      [WIDTH-1:0] count_value,
  output logic      [WIDTH-1:0] next_value,
  output logic                  wrapped
);

  logic [WIDTH:0]   sum;
  logic [WIDTH:0]   diff;
  logic [WIDTH-1:0] stepped;
  logic             carry;

  // ********************************************************************
  // Next value.
  // ********************************************************************
  always_comb begin
    sum     = {1'b0, count_value} + {1'b0, STEP};
    diff    = {1'b0, count_value} - {1'b0, STEP};
    stepped = count_up ? sum[WIDTH-1:0] : diff[WIDTH-1:0];
    carry   = count_up ? sum[WIDTH] : diff[WIDTH];
    if (clear) begin
      next_value = INIT;
    end else if (!advance) begin
      next_value = count_value;
    end else if (load) begin
      next_value = load_value;
    end else if (restart) begin
      next_value = INIT;
    end else begin
      next_value = stepped;
    end
    wrapped = !clear && advance && !load && !restart && carry;
  end

  // ********************************************************************
  // Count register.
  // ********************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value <= INIT;
    end else if (aclken) begin
      count_value <= next_value;
    end
  end

endmodule // ucnt_core

`default_nettype wire

// ==== core/ucnt_top.sv ====
`default_nettype none
module ucnt_top
  import ucnt_pkg::*;
#(
  parameter int unsigned WIDTH          = 8,
  parameter int unsigned BIN_PT         = 0,
  parameter logic        SIGNED_OUT     = 1'b0,
  parameter ucnt_kind_t  KIND           = UCNT_FREE,
  parameter ucnt_dir_t   DIR            = UCNT_DIR_UP,
  parameter logic [63:0] INIT_VALUE     = 64'h0,
  parameter logic [63:0] STEP_VALUE     = 64'h1,
  parameter logic [63:0] TERMINAL_VALUE = 64'hff,
  parameter logic        TERMINAL_INF   = 1'b0,
  parameter logic        HAS_LOAD       = 1'b0,
  parameter logic        HAS_CLEAR      = 1'b1,
  parameter logic        HAS_ENABLE     = 1'b1
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   aclken,
  input  wire logic [UCNT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [UCNT_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic      [1:0]             s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [UCNT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic      [UCNT_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]             s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   count_en,
  input  wire logic                   sync_clear,
  input  wire logic                   count_up,
  input  wire logic                   load,
  input  wire logic [WIDTH-1:0]       load_data,
  output logic      [WIDTH-1:0]       count_value,
  output logic                        at_terminal
);

  // ********************************************************************
  // Derived configuration.
  // ********************************************************************
  localparam logic [63:0] W_MASK     = (WIDTH >= 64) ? 64'hffffffffffffffff
                                                     : ((64'h1 << WIDTH) - 64'h1);
  localparam logic [63:0] MAX_FULL   = SIGNED_OUT ? (W_MASK >> 1) : W_MASK;
  localparam logic [63:0] INIT_FULL  = INIT_VALUE & W_MASK;
  localparam logic [63:0] STEP_FULL  = STEP_VALUE & W_MASK;
  localparam logic [63:0] TERM_FULL  = TERMINAL_INF ? MAX_FULL
                                                    : (TERMINAL_VALUE & W_MASK);
  localparam logic [63:0] UP_DIST    = (TERM_FULL - INIT_FULL) & W_MASK;
  localparam logic [63:0] DOWN_DIST  = (INIT_FULL - TERM_FULL) & W_MASK;
  localparam logic [63:0] DIST       = (DIR == UCNT_DIR_DOWN) ? DOWN_DIST : UP_DIST;
  localparam logic [63:0] STEP_SAFE  = (STEP_FULL == 64'h0) ? 64'h1 : STEP_FULL;
  localparam logic        LIMITED    = (KIND == UCNT_LIMITED);
  localparam logic        LOAD_OK    = HAS_LOAD && !LIMITED;
  localparam logic [WIDTH-1:0] INIT_W = INIT_FULL[WIDTH-1:0];
  localparam logic [WIDTH-1:0] STEP_W = STEP_FULL[WIDTH-1:0];
  localparam logic [WIDTH-1:0] TERM_W = TERM_FULL[WIDTH-1:0];

  // ********************************************************************
  // Elaboration checks.
  // ********************************************************************
  if (WIDTH < 1 || WIDTH > UCNT_MAX_WIDTH) begin : g_bad_width
    $error("Counter width must lie between 1 and 64 bits.");
  end
  if (BIN_PT > WIDTH) begin : g_bad_binpt
    $error("Binary point lies outside the counter width.");
  end
  if (STEP_FULL == 64'h0) begin : g_bad_step
    $error("Step must not be zero.");
  end
  if (LIMITED && TERM_FULL == INIT_FULL) begin : g_bad_term
    $error("Terminal value equals the initial value.");
  end
  if (LIMITED && (DIST % STEP_SAFE) != 64'h0) begin : g_bad_div
    $error("Step does not divide the counting distance.");
  end
  if (HAS_LOAD && LIMITED) begin : g_bad_load
    $error("Load is only available on the free-running type.");
  end

  // ********************************************************************
  // Signals.
  // ********************************************************************
  ucnt_wr_state_t         wr_state_q;
  ucnt_wr_state_t         wr_state_d;
  logic [UCNT_ADDR_W-1:0] aw_addr_q;
  logic [UCNT_DATA_W-1:0] w_data_q;
  logic [3:0]             w_strb_q;
  logic [1:0]             bresp_q;
  logic [UCNT_ADDR_W-1:0] wr_addr;
  logic [UCNT_DATA_W-1:0] wr_data;
  logic [3:0]             wr_strb;
  logic                   aw_fire;
  logic                   w_fire;
  logic                   wr_commit;
  logic                   wr_ok;
  logic                   rvalid_q;
  logic [UCNT_DATA_W-1:0] rdata_q;
  logic [1:0]             rresp_q;
  logic [UCNT_DATA_W-1:0] rd_data;
  logic                   rd_err;
  logic                   ar_fire;
  logic                   run_q;
  logic                   soft_clear_q;
  logic                   soft_load_q;
  logic [63:0]            load_reg_q;
  logic                   term_seen_q;
  logic                   wrap_seen_q;
  logic                   at_term_q;
  logic                   dir_up;
  logic                   clear_req;
  logic                   load_req;
  logic                   advance;
  logic [WIDTH-1:0]       load_value;
  logic [WIDTH-1:0]       count_q;
  logic [WIDTH-1:0]       count_d;
  logic                   wrap_evt;
  logic [63:0]            count_ext;

  // ********************************************************************
  // Counter control.
  // ********************************************************************
  always_comb begin
    case (DIR)
      UCNT_DIR_UP:     dir_up = 1'b1;
      UCNT_DIR_DOWN:   dir_up = 1'b0;
      UCNT_DIR_UPDOWN: dir_up = count_up;
      default:         dir_up = 1'b1;
    endcase
  end

  assign clear_req  = (HAS_CLEAR && sync_clear) || soft_clear_q;
  assign advance    = run_q && (!HAS_ENABLE || count_en);
  assign load_req   = LOAD_OK && (load || soft_load_q);
  assign load_value = load ? load_data : load_reg_q[WIDTH-1:0];

  ucnt_core #(
    .WIDTH (WIDTH),
    .INIT  (INIT_W),
    .STEP  (STEP_W)
  ) u_core (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .aclken      (aclken),
    .clear       (clear_req),
    .advance     (advance),
    .load        (load_req),
    .load_value  (load_value),
    .restart     (LIMITED && at_term_q),
    .count_up    (dir_up),
    .count_value (count_q),
    .next_value  (count_d),
    .wrapped     (wrap_evt)
  );

  // ********************************************************************
  // Terminal comparator.
  // ********************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      at_term_q <= 1'b0;
    end else if (aclken) begin
      at_term_q <= (count_d == TERM_W);
    end
  end

  assign count_value = count_q;
  assign at_terminal = at_term_q;

  for (genvar gi = 0; gi < 64; gi++) begin : g_ext
    if (gi < WIDTH) begin : g_bit
      assign count_ext[gi] = count_q[gi];
    end else begin : g_sign
      assign count_ext[gi] = SIGNED_OUT && count_q[WIDTH-1];
    end
  end

  // ********************************************************************
  // Write channel.
  // ********************************************************************
  assign s_axi_awready = aclken && (wr_state_q == UCNT_WR_IDLE ||
                                    wr_state_q == UCNT_WR_HAVE_DATA);
  assign s_axi_wready  = aclken && (wr_state_q == UCNT_WR_IDLE ||
                                    wr_state_q == UCNT_WR_HAVE_ADDR);
  assign s_axi_bvalid  = (wr_state_q == UCNT_WR_RESP);
  assign s_axi_bresp   = bresp_q;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign wr_addr       = (wr_state_q == UCNT_WR_HAVE_ADDR) ? aw_addr_q : s_axi_awaddr;
  assign wr_data       = (wr_state_q == UCNT_WR_HAVE_DATA) ? w_data_q : s_axi_wdata;
  assign wr_strb       = (wr_state_q == UCNT_WR_HAVE_DATA) ? w_strb_q : s_axi_wstrb;
  assign wr_commit     = (wr_state_d == UCNT_WR_RESP) && (wr_state_q != UCNT_WR_RESP);

  always_comb begin
    case (wr_addr)
      UCNT_ADDR_CTRL, UCNT_ADDR_STATUS, UCNT_ADDR_COUNT_LO, UCNT_ADDR_COUNT_HI,
      UCNT_ADDR_LOAD_LO, UCNT_ADDR_LOAD_HI, UCNT_ADDR_CONFIG: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    wr_state_d = wr_state_q;
    case (wr_state_q)
      UCNT_WR_IDLE: begin
        if (aw_fire && w_fire) begin
          wr_state_d = UCNT_WR_RESP;
        end else if (aw_fire) begin
          wr_state_d = UCNT_WR_HAVE_ADDR;
        end else if (w_fire) begin
          wr_state_d = UCNT_WR_HAVE_DATA;
        end
      end
      UCNT_WR_HAVE_ADDR: begin
        if (w_fire) begin
          wr_state_d = UCNT_WR_RESP;
        end
      end
      UCNT_WR_HAVE_DATA: begin
        if (aw_fire) begin
          wr_state_d = UCNT_WR_RESP;
        end
      end
      UCNT_WR_RESP: begin
        if (s_axi_bready) begin
          wr_state_d = UCNT_WR_IDLE;
        end
      end
      default: wr_state_d = UCNT_WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= UCNT_WR_IDLE;
    end else if (aclken) begin
      wr_state_q <= wr_state_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bresp_q   <= UCNT_RESP_OKAY;
    end else if (aclken) begin
      if (aw_fire) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_commit) begin
        bresp_q <= wr_ok ? UCNT_RESP_OKAY : UCNT_RESP_SLVERR;
      end
    end
  end

  // ********************************************************************
  // Control register and software pulses.
  // ********************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q        <= UCNT_CTRL_RUN_RST;
      soft_clear_q <= 1'b0;
      soft_load_q  <= 1'b0;
    end else if (aclken) begin
      soft_clear_q <= 1'b0;
      soft_load_q  <= 1'b0;
      if (wr_commit && wr_addr == UCNT_ADDR_CTRL && wr_strb[0]) begin
        run_q        <= wr_data[UCNT_CTRL_RUN_BIT];
        soft_clear_q <= wr_data[UCNT_CTRL_CLEAR_BIT];
        soft_load_q  <= wr_data[UCNT_CTRL_LOAD_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_reg_q <= '0;
    end else if (aclken && wr_commit) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b] && wr_addr == UCNT_ADDR_LOAD_LO) begin
          load_reg_q[b*8 +: 8] <= wr_data[b*8 +: 8];
        end
        if (wr_strb[b] && wr_addr == UCNT_ADDR_LOAD_HI) begin
          load_reg_q[32 + b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
    end
  end

  // ********************************************************************
  // Sticky status flags.
  // ********************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_seen_q <= 1'b0;
    end else if (aclken) begin
      if (at_term_q) begin
        term_seen_q <= 1'b1;
      end else if (wr_commit && wr_addr == UCNT_ADDR_STATUS && wr_strb[0] &&
                   wr_data[UCNT_STAT_TERM_BIT]) begin
        term_seen_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_seen_q <= 1'b0;
    end else if (aclken) begin
      if (wrap_evt) begin
        wrap_seen_q <= 1'b1;
      end else if (wr_commit && wr_addr == UCNT_ADDR_STATUS && wr_strb[0] &&
                   wr_data[UCNT_STAT_WRAP_BIT]) begin
        wrap_seen_q <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Read channel.
  // ********************************************************************
  assign s_axi_arready = aclken && !rvalid_q;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    case (s_axi_araddr)
      UCNT_ADDR_CTRL: rd_data[UCNT_CTRL_RUN_BIT] = run_q;
      UCNT_ADDR_STATUS: begin
        rd_data[UCNT_STAT_TERM_BIT] = term_seen_q;
        rd_data[UCNT_STAT_WRAP_BIT] = wrap_seen_q;
        rd_data[UCNT_STAT_UP_BIT]   = dir_up;
      end
      UCNT_ADDR_COUNT_LO: rd_data = count_ext[31:0];
      UCNT_ADDR_COUNT_HI: rd_data = count_ext[63:32];
      UCNT_ADDR_LOAD_LO:  rd_data = load_reg_q[31:0];
      UCNT_ADDR_LOAD_HI:  rd_data = load_reg_q[63:32];
      UCNT_ADDR_CONFIG: begin
        rd_data[UCNT_CFG_WIDTH_POS +: 8] = 8'(WIDTH);
        rd_data[UCNT_CFG_BINPT_POS +: 8] = 8'(BIN_PT);
        rd_data[UCNT_CFG_SIGNED_BIT]     = SIGNED_OUT;
        rd_data[UCNT_CFG_KIND_BIT]       = LIMITED;
        rd_data[UCNT_CFG_DIR_POS +: 2]   = DIR;
        rd_data[UCNT_CFG_LOAD_BIT]       = LOAD_OK;
        rd_data[UCNT_CFG_CLEAR_BIT]      = HAS_CLEAR;
        rd_data[UCNT_CFG_EN_BIT]         = HAS_ENABLE;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= UCNT_RESP_OKAY;
    end else if (aclken) begin
      if (ar_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_data;
        rresp_q  <= rd_err ? UCNT_RESP_SLVERR : UCNT_RESP_OKAY;
      end else if (rvalid_q && s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule // ucnt_top

`default_nettype wire

// ==== bench/ucnt_top_monitor.sv ====
`default_nettype none
module ucnt_top_monitor #(
  parameter int unsigned      WIDTH = 8,
  parameter logic [WIDTH-1:0] INIT  = '0,
  parameter logic [WIDTH-1:0] STEP  = '1
) (
  input wire logic             aclk,
  input wire logic             aresetn,
  input wire logic             aclken,
  input wire logic             count_en,
  input wire logic             sync_clear,
  input wire logic             count_up,
  input wire logic             load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic [WIDTH-1:0] count_value,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_arready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************************************
  // Counter and read channel checks.
  // ********************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire go = aclken && count_en && !sync_clear;
  a_reset_init: assert property ($rose(aresetn) |-> count_value == INIT)
    else $error("count not initial after reset");
  a_clear_init: assert property (aclken && sync_clear |=> count_value == INIT)
    else $error("clear did not restore initial value");
  a_hold_off: assert property (aclken && !count_en && !sync_clear |=> $stable(count_value))
    else $error("count moved while disabled");
  a_load_take: assert property (go && load |=> count_value == $past(load_data))
    else $error("load data not taken");
  a_step_up: assert property (go && !load && count_up |=>
    count_value == $past(count_value) + STEP) else $error("up step wrong");
  a_step_down: assert property (go && !load && !count_up |=>
    count_value == $past(count_value) - STEP) else $error("down step wrong");
  a_freeze_off: assert property (!aclken |=> $stable(count_value))
    else $error("count moved without clock enable");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during read answer");
  cover property (go && load);
  cover property (aclken && sync_clear && !count_en);
  cover property (go && !count_up && count_value < STEP);
endmodule // ucnt_top_monitor
`default_nettype wire

// ==== bench/ucnt_fabric.sv ====
`default_nettype none
module ucnt_fabric #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             aclk,
  input  wire logic [3:0]       req,
  input  wire logic [WIDTH-1:0] req_data,
  output logic                  count_en,
  output logic                  sync_clear,
  output logic                  count_up,
  output logic                  load,
  output logic      [WIDTH-1:0] load_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WIDTH-1:0] last_q;
  assign {count_en, sync_clear, count_up, load} = req;
  always_ff @(posedge aclk) begin
    if (req[0]) last_q <= req_data;
  end
  // Released data lines show the inverse of the last driven value.
  assign load_data = req[0] ? req_data : ~last_q;
endmodule // ucnt_fabric
`default_nettype wire

// ==== bench/ucnt_top_tb.sv ====
`default_nettype none
module ucnt_top_tb;
  import ucnt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, aclken = 1, s_axi_bready = 0, s_axi_rready = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  req = 0, s_axi_wstrb = 0;
  logic [7:0]  req_data = 0, load_data, count_value;
  logic        count_en, sync_clear, count_up, load, at_terminal;
  int          bad_count = 0, n_compared = 0, cyc = 0;
  initial forever #5 aclk = ~aclk;
  ucnt_top #(.DIR(UCNT_DIR_UPDOWN), .INIT_VALUE(64'h5), .STEP_VALUE(64'h3),
    .HAS_LOAD(1'b1)) u_dut (.aclk, .aresetn, .aclken, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .count_en, .sync_clear, .count_up, .load, .load_data, .count_value, .at_terminal);
  ucnt_fabric u_fab (.aclk, .req, .req_data, .count_en, .sync_clear, .count_up, .load,
    .load_data);
  task finish_test();
    if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      bad_count++;
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw, tr;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end while (!tr);
    s_axi_bready <= 0;
  endtask
  task rd(input logic [4:0] a);
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rv = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
    end while (!tr);
    s_axi_rready <= 0;
  endtask
  // Code c is {clock enable, enable, clear, up, load}; one hold cycle follows.
  task st(input logic [4:0] c, input logic [7:0] d, input logic [7:0] e);
    @(posedge aclk);
    aclken <= c[4];
    req <= c[3:0];
    req_data <= d;
    @(posedge aclk);
    aclken <= 1;
    req <= 0;
    #1;
    chk("count_value", e, count_value);
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    #1;
    chk("count_value", 32'h5, count_value);
    st(5'h1a, 8'h00, 8'h08);
    st(5'h18, 8'h00, 8'h05);
    st(5'h18, 8'h00, 8'h02);
    st(5'h18, 8'h00, 8'hff);
    chk("at_terminal", 32'h1, {31'h0, at_terminal});
    st(5'h1a, 8'h00, 8'h02);
    chk("at_terminal", 32'h0, {31'h0, at_terminal});
    st(5'h1b, 8'ha5, 8'ha5);
    st(5'h15, 8'h77, 8'h05);
    st(5'h13, 8'h33, 8'h05);
    st(5'h0a, 8'h00, 8'h05);
    st(5'h19, 8'hfe, 8'hfe);
    st(5'h1a, 8'h00, 8'h01);
    rd(UCNT_ADDR_CONFIG);
    chk("config", 32'h00780008, rv);
    rd(UCNT_ADDR_COUNT_LO);
    chk("count_lo", 32'h1, rv);
    rd(UCNT_ADDR_STATUS);
    chk("status", 32'h3, rv);
    wr(UCNT_ADDR_STATUS, 32'h3, 4'h1);
    chk("bresp", UCNT_RESP_OKAY, rsp);
    rd(UCNT_ADDR_STATUS);
    chk("status", 32'h0, rv);
    wr(UCNT_ADDR_LOAD_LO, 32'h12345678, 4'hf);
    chk("bresp", UCNT_RESP_OKAY, rsp);
    rd(UCNT_ADDR_LOAD_LO);
    chk("load_lo", 32'h12345678, rv);
    wr(UCNT_ADDR_LOAD_LO, 32'haaaaaaaa, 4'h1);
    rd(UCNT_ADDR_LOAD_LO);
    chk("load_lo", 32'h123456aa, rv);
    rd(5'h1c);
    chk("rresp", UCNT_RESP_SLVERR, rsp);
    wr(5'h1c, 32'h0, 4'hf);
    chk("bresp", UCNT_RESP_SLVERR, rsp);
    finish_test();
  end
endmodule // ucnt_top_tb
bind ucnt_top ucnt_top_monitor #(.WIDTH(WIDTH), .INIT(INIT_W), .STEP(STEP_W)) u_mon (.aclk,
  .aresetn, .aclken, .count_en, .sync_clear, .count_up, .load, .load_data, .count_value,
  .s_axi_rvalid, .s_axi_arready);
`default_nettype wire
